// ==== ladbc_pkg.sv ====
// shared constants and carrier types of the ladder compare and bit-op datapath
package ladbc_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned DWORD_W = 32;
  localparam int unsigned OP_W = 9;
  localparam int unsigned TMR_NUM_W = 8;
  localparam int unsigned TMR_VAL_W = 15;

  // opcodes of the parallel compare contacts, the bit-addressed word group and the accumulating timer
  localparam logic [OP_W-1:0] OP_CMP_EQ = 9'h0f0;
  localparam logic [OP_W-1:0] OP_CMP_GT = 9'h0f1;
  localparam logic [OP_W-1:0] OP_CMP_LT = 9'h0f2;
  localparam logic [OP_W-1:0] OP_CMP_NE = 9'h0f4;
  localparam logic [OP_W-1:0] OP_CMP_LE = 9'h0f5;
  localparam logic [OP_W-1:0] OP_CMP_GE = 9'h0f6;
  localparam logic [OP_W-1:0] OP_BIT_OUT = 9'h10a;
  localparam logic [OP_W-1:0] OP_BIT_SET = 9'h10b;
  localparam logic [OP_W-1:0] OP_BIT_CLR = 9'h10c;
  localparam logic [OP_W-1:0] OP_BIT_LDO = 9'h10d;
  localparam logic [OP_W-1:0] OP_BIT_LDC = 9'h10e;
  localparam logic [OP_W-1:0] OP_ACC_TMR = 9'h1f0;

  // highest legal bit index per form
  localparam logic [DWORD_W-1:0] IDX_MAX_16 = 32'h0000_000f;
  localparam logic [DWORD_W-1:0] IDX_MAX_32 = 32'h0000_001f;
  localparam logic [TMR_VAL_W-1:0] TMR_PRESET_MAX = 15'h7fff;
  localparam logic [TMR_VAL_W-1:0] TMR_ACC_ONE = 15'h0001;

  // timer base and error-indicator half period
  localparam longint unsigned CLK_HZ = 20_000_000;
  localparam longint unsigned TMR_BASE_NS = 100_000;
  localparam longint unsigned BLINK_HALF_NS = 250_000_000;
  localparam int unsigned TMR_BASE_CYC = int'((TMR_BASE_NS * CLK_HZ) / 1_000_000_000);
  localparam int unsigned BLINK_HALF_CYC = int'((BLINK_HALF_NS * CLK_HZ) / 1_000_000_000);

  typedef enum logic [1:0] {
    LADBC_ST_RUN = 2'b00,
    LADBC_ST_FAULT = 2'b01
  } ladbc_state_e;

  typedef struct packed {
    logic valid;
    logic [OP_W-1:0] op;
    logic wide;
    logic ctr32;
    logic rung_in;
    logic [WORD_W-1:0] s1_lo;
    logic [WORD_W-1:0] s1_hi;
    logic [WORD_W-1:0] s2_lo;
    logic [WORD_W-1:0] s2_hi;
  } ladbc_req_s;

  typedef struct packed {
    logic valid;
    logic rung_out;
    logic dest_we;
    logic [DWORD_W-1:0] dest;
    logic err;
  } ladbc_rsp_s;

endpackage

// ==== ladbc_cmp.sv ====
// signed relation evaluator for the parallel compare contacts
`timescale 1ns/1ps
module ladbc_cmp
  import ladbc_pkg::*;
(
  input wire logic signed [DWORD_W-1:0] a,
  input wire logic signed [DWORD_W-1:0] b,
  input wire logic [OP_W-1:0] op,
  output logic hit,
  output logic known
);

  wire logic eq = (a == b);
  wire logic lt = (a < b);
  wire logic gt = (a > b);

  always_comb begin
    hit = 1'b0;
    known = 1'b1;
    case (op)
      OP_CMP_EQ: hit = eq;
      OP_CMP_GT: hit = gt;
      OP_CMP_LT: hit = lt;
      OP_CMP_NE: hit = !eq;
      OP_CMP_LE: hit = !gt;
      OP_CMP_GE: hit = !lt;
      default: known = 1'b0;
    endcase
  end

endmodule

// ==== ladbc_exec.sv ====
// execution datapath: parallel compare contacts, accumulating timer, bit-addressed word ops
//
// Overview of operation
// - parallel compare is a contact; opcodes 240..246 pick eq, gt, lt, ne, le, ge.
// - operands compare as signed two's complement; bit 15 or bit 31 marks negative.
// - narrow compare given a 32-bit counter raises program error and blinks the indicator.
// - a 32-bit operand is two words, lower-numbered register holding the low word.
// - accumulating timer instruction drives the selected timer coil, timers 0 to 255.
// - accumulated value reaching preset turns open contact on, closed contact off.
// - bit index accepted 0..15 for narrow form, 0..31 for wide form.
// - bit output drives the chosen bit to the rung value.
// - index value n selects bit n of the destination word.
// - bit set turns the chosen bit on and keeps it until a bit reset.
// - bit reset forces the chosen bit off.
// - open bit load is true when the indexed source bit is one.
// - closed bit load is true when the indexed source bit is zero.
`timescale 1ns/1ps
module ladbc_exec
  import ladbc_pkg::*;
#(
  parameter int unsigned NUM_TMR = 256,
  parameter int unsigned TICK_CYC = TMR_BASE_CYC,
  parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire ladbc_req_s req,
  input wire logic err_clr,
  output ladbc_rsp_s rsp_ff,
  output logic prog_err_ff,
  output logic err_led_ff,
  output logic tmr_no_ff,
  output logic tmr_nc_ff,
  output logic [NUM_TMR-1:0] tmr_coil_ff,
  output logic [NUM_TMR-1:0] tmr_done_ff
);

  localparam int unsigned TICK_W = $clog2(TICK_CYC + 1);
  localparam int unsigned BLINK_W = $clog2(BLINK_CYC + 1);
  localparam int unsigned IDX_W = $clog2(DWORD_W);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_CYC - 1);

  // operand assembly, narrow words sign-extend from their top bit
  wire logic [DWORD_W-1:0] s1_wide = {req.s1_hi, req.s1_lo};
  wire logic [DWORD_W-1:0] s2_wide = {req.s2_hi, req.s2_lo};
  wire logic [DWORD_W-1:0] s1_narrow = {{WORD_W{req.s1_lo[WORD_W-1]}}, req.s1_lo};
  wire logic [DWORD_W-1:0] s2_narrow = {{WORD_W{req.s2_lo[WORD_W-1]}}, req.s2_lo};
  wire logic [DWORD_W-1:0] op_a = req.wide ? s1_wide : s1_narrow;
  wire logic [DWORD_W-1:0] op_b = req.wide ? s2_wide : s2_narrow;

  wire logic cmp_hit;
  wire logic is_cmp;

  ladbc_cmp u_cmp (
    .a(op_a),
    .b(op_b),
    .op(req.op),
    .hit(cmp_hit),
    .known(is_cmp)
  );

  // instruction decode
  wire logic go = ce && req.valid;
  wire logic is_bit_output_instr = (req.op == OP_BIT_OUT);
  wire logic is_bit_latch_on_instr = (req.op == OP_BIT_SET);
  wire logic is_bclr = (req.op == OP_BIT_CLR);
  wire logic is_bldo = (req.op == OP_BIT_LDO);
  wire logic is_bldc = (req.op == OP_BIT_LDC);
  wire logic is_tmr = (req.op == OP_ACC_TMR);
  wire logic is_bitop = is_bit_output_instr || is_bit_latch_on_instr || is_bclr || is_bldo || is_bldc;
  wire logic is_known = is_cmp || is_bitop || is_tmr;

  // a narrow compare fed with a 32-bit counter is a program error
  wire logic ctr_err = is_cmp && !req.wide && req.ctr32;

  // index n is the whole second operand, limited per form
  wire logic [DWORD_W-1:0] idx_max = req.wide ? IDX_MAX_32 : IDX_MAX_16;
  wire logic idx_ok = (s2_wide <= idx_max);
  wire logic [IDX_W-1:0] idx = s2_wide[IDX_W-1:0];
  wire logic idx_err = is_bitop && !idx_ok;
  wire logic req_err = ctr_err || idx_err || !is_known;

  // bit n of the addressed word, narrow form keeps upper word untouched
  wire logic [DWORD_W-1:0] bit_mask = idx_ok ? (DWORD_W'(1) << idx) : '0;
  wire logic src_bit = |(s1_wide & bit_mask);
  wire logic [DWORD_W-1:0] word_set = s1_wide | bit_mask;
  wire logic [DWORD_W-1:0] word_clr = s1_wide & ~bit_mask;

  logic [DWORD_W-1:0] nxt_dest;
  logic nxt_we;
  logic nxt_rung;

  always_comb begin
    nxt_dest = s1_wide;
    nxt_we = 1'b0;
    nxt_rung = req.rung_in;
    if (req_err) begin
      nxt_rung = 1'b0;
    end else if (is_cmp) begin
      nxt_rung = req.rung_in || cmp_hit;
    end else if (is_bit_output_instr) begin
      nxt_dest = req.rung_in ? word_set : word_clr;
      nxt_we = 1'b1;
    end else if (is_bit_latch_on_instr) begin
      nxt_dest = word_set;
      nxt_we = req.rung_in;
    end else if (is_bclr) begin
      nxt_dest = word_clr;
      nxt_we = req.rung_in;
    end else if (is_bldo) begin
      nxt_rung = src_bit;
    end else if (is_bldc) begin
      nxt_rung = !src_bit;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_ff <= '0;
    end else if (ce) begin
      rsp_ff.valid <= req.valid;
      rsp_ff.rung_out <= req.valid && nxt_rung;
      rsp_ff.dest_we <= req.valid && nxt_we;
      rsp_ff.dest <= req.valid ? nxt_dest : '0;
      rsp_ff.err <= req.valid && req_err;
    end
  end

  // time base for all timers
  logic [TICK_W-1:0] tick_cnt_ff;
  wire logic tick = (tick_cnt_ff == TICK_LAST);
  wire logic [TICK_W-1:0] nxt_tick_cnt = tick ? '0 : tick_cnt_ff + TICK_W'(1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= '0;
    end else if (ce) begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  // accumulating timers; value is kept while the coil is off
  wire logic tmr_go = go && is_tmr;
  wire logic [TMR_NUM_W-1:0] tmr_sel = req.s1_lo[TMR_NUM_W-1:0];
  wire logic [TMR_VAL_W-1:0] tmr_preset = req.s2_lo[TMR_VAL_W-1:0];
  logic [TMR_VAL_W-1:0] acc_ff [NUM_TMR];
  logic [TMR_VAL_W-1:0] preset_ff [NUM_TMR];
  logic [NUM_TMR-1:0] done_now;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
      wire logic hit = tmr_go && (tmr_sel == TMR_NUM_W'(gi));
      wire logic [TMR_VAL_W-1:0] nxt_preset = hit ? tmr_preset : preset_ff[gi];
      wire logic nxt_coil = hit ? req.rung_in : tmr_coil_ff[gi];
      wire logic run = tick && tmr_coil_ff[gi] && (acc_ff[gi] < preset_ff[gi]);
      wire logic [TMR_VAL_W-1:0] nxt_acc = run ? acc_ff[gi] + TMR_ACC_ONE : acc_ff[gi];
      assign done_now[gi] = (nxt_acc >= nxt_preset);

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          acc_ff[gi] <= '0;
          preset_ff[gi] <= TMR_PRESET_MAX;
          tmr_coil_ff[gi] <= 1'b0;
          tmr_done_ff[gi] <= 1'b0;
        end else if (ce) begin
          acc_ff[gi] <= nxt_acc;
          preset_ff[gi] <= nxt_preset;
          tmr_coil_ff[gi] <= nxt_coil;
          tmr_done_ff[gi] <= done_now[gi];
        end
      end
    end
  endgenerate

  // contacts of the timer just addressed, as seen after this execution
  wire logic sel_done = done_now[tmr_sel];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_no_ff <= 1'b0;
      tmr_nc_ff <= 1'b1;
    end else if (tmr_go) begin
      tmr_no_ff <= sel_done;
      tmr_nc_ff <= !sel_done;
    end
  end

  // program error: sticky, a new error in the clear cycle still lands
  ladbc_state_e state_ff;
  ladbc_state_e nxt_state;
  wire logic err_evt = go && req_err;

  always_comb begin
    case (state_ff)
      LADBC_ST_RUN: nxt_state = err_evt ? LADBC_ST_FAULT : LADBC_ST_RUN;
      LADBC_ST_FAULT: nxt_state = (err_clr && !err_evt) ? LADBC_ST_RUN : LADBC_ST_FAULT;
      default: nxt_state = LADBC_ST_RUN;
    endcase
  end

  // blink counter only runs while faulted, so the indicator starts lit
  logic [BLINK_W-1:0] blink_cnt_ff;
  wire logic faulted = (nxt_state == LADBC_ST_FAULT);
  wire logic blink_wrap = (blink_cnt_ff == BLINK_LAST);
  wire logic [BLINK_W-1:0] nxt_blink_cnt =
    (!faulted || blink_wrap) ? '0 : blink_cnt_ff + BLINK_W'(1);
  wire logic nxt_led = !faulted ? 1'b0 :
    (state_ff == LADBC_ST_RUN) ? 1'b1 :
    blink_wrap ? !err_led_ff : err_led_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= LADBC_ST_RUN;
      blink_cnt_ff <= '0;
      prog_err_ff <= 1'b0;
      err_led_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      blink_cnt_ff <= nxt_blink_cnt;
      prog_err_ff <= faulted;
      err_led_ff <= nxt_led;
    end
  end

endmodule

// ==== ladbc_chk.sv ====
// port assertions for the ladder compare and bit-op datapath
`timescale 1ns/1ps
module ladbc_chk
  import ladbc_pkg::*;
#(
  parameter int unsigned NUM_TMR = 256
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire ladbc_req_s req,
  input wire logic err_clr,
  input wire ladbc_rsp_s rsp_ff,
  input wire logic prog_err_ff,
  input wire logic err_led_ff,
  input wire logic tmr_no_ff,
  input wire logic tmr_nc_ff,
  input wire logic [NUM_TMR-1:0] tmr_coil_ff,
  input wire logic [NUM_TMR-1:0] tmr_done_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire go = ce && req.valid;
  wire cmp = req.op inside {OP_CMP_EQ, OP_CMP_GT, OP_CMP_LT, OP_CMP_NE, OP_CMP_LE, OP_CMP_GE};
  wire bop = req.op inside {[OP_BIT_OUT:OP_BIT_LDC]};
  wire [31:0] idx = {req.s2_hi, req.s2_lo};
  wire idx_ok = idx <= (req.wide ? IDX_MAX_32 : IDX_MAX_16);
  AST_RSP_ONE: assert property (go |=> rsp_ff.valid)
    else $error("request not answered");
  AST_NARROW_CTR: assert property (go && cmp && req.ctr32 && !req.wide |=>
    rsp_ff.err && !rsp_ff.rung_out) else $error("narrow counter compare not refused");
  AST_ERR_STICKY: assert property (rsp_ff.err |-> prog_err_ff)
    else $error("program error not raised");
  AST_LED_ON: assert property ($rose(prog_err_ff) |-> err_led_ff)
    else $error("indicator not lit");
  AST_OR_RUNG: assert property (go && cmp && req.rung_in && !(req.ctr32 && !req.wide) |=>
    rsp_ff.rung_out) else $error("incoming rung not passed on");
  AST_BIT_OUT: assert property (go && req.op == OP_BIT_OUT && idx_ok |=> rsp_ff.dest_we)
    else $error("bit output not written");
  AST_IDX_RANGE: assert property (go && bop && !idx_ok |=> rsp_ff.err && !rsp_ff.dest_we)
    else $error("bad index accepted");
  AST_COIL: assert property (go && req.op == OP_ACC_TMR |=>
    tmr_coil_ff[$past(req.s1_lo[7:0])] == $past(req.rung_in)) else $error("coil wrong");
  AST_CONTACT: assert property (tmr_no_ff != tmr_nc_ff)
    else $error("timer contacts not complementary");
  AST_PRESET_ZERO: assert property (go && req.op == OP_ACC_TMR && req.s2_lo[14:0] == 0 |=>
    tmr_no_ff && !tmr_nc_ff) else $error("zero preset did not close the contact");
  cover property (go && cmp && req.wide);
  cover property (go && bop && !idx_ok);
  cover property ($rose(tmr_no_ff));
endmodule
bind ladbc_exec ladbc_chk #(.NUM_TMR(NUM_TMR)) u_chk (.mclk, .rst_n, .ce, .req, .err_clr,
  .rsp_ff, .prog_err_ff, .err_led_ff, .tmr_no_ff, .tmr_nc_ff, .tmr_coil_ff, .tmr_done_ff);

// ==== tb_ladder_bit_compare_exec.sv ====
// self-checking bench for the ladder compare and bit-op datapath
`timescale 1ns/1ps
module tb_ladder_bit_compare_exec;
  import ladbc_pkg::*;
  localparam int TICK = 4;
  logic mclk = 0, rst_n = 0, ce = 0, err_clr = 0;
  ladbc_req_s req = '0, r;
  ladbc_rsp_s rsp_ff;
  logic prog_err_ff, err_led_ff, tmr_no_ff, tmr_nc_ff;
  logic [255:0] tmr_coil_ff, tmr_done_ff;
  int err_total = 0, tests_run = 0, cyc = 0;
  bit kr, kb;
  ladbc_rsp_s exp_q [$];
  logic [OP_W-1:0] ops [11] = '{OP_CMP_EQ, OP_CMP_GT, OP_CMP_LT, OP_CMP_NE, OP_CMP_LE,
    OP_CMP_GE, OP_BIT_OUT, OP_BIT_SET, OP_BIT_CLR, OP_BIT_LDO, OP_BIT_LDC};
  always #25 mclk = ~mclk;
  ladbc_exec #(.NUM_TMR(256), .TICK_CYC(TICK), .BLINK_CYC(8)) DUT (.mclk, .rst_n, .ce,
    .req, .err_clr, .rsp_ff, .prog_err_ff, .err_led_ff, .tmr_no_ff, .tmr_nc_ff,
    .tmr_coil_ff, .tmr_done_ff);
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // the whole run needs a few hundred cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (e !== s) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic ladbc_rsp_s model(ladbc_req_s q);
    ladbc_rsp_s e;
    longint a, b;
    logic [31:0] w, n;
    bit c;
    e = '0;
    e.valid = 1;
    w = {q.s1_hi, q.s1_lo};
    n = {q.s2_hi, q.s2_lo};
    a = q.wide ? longint'($signed(w)) : longint'($signed(q.s1_lo));
    b = q.wide ? longint'($signed(n)) : longint'($signed(q.s2_lo));
    kr = 0;
    kb = 0;
    if (q.op inside {[OP_CMP_EQ:OP_CMP_GE]}) begin
      kr = 1;
      case (q.op)
        OP_CMP_EQ: c = a == b;
        OP_CMP_GT: c = a > b;
        OP_CMP_LT: c = a < b;
        OP_CMP_NE: c = a != b;
        OP_CMP_LE: c = a <= b;
        default: c = a >= b;
      endcase
      e.err = q.ctr32 && !q.wide;
      e.rung_out = !e.err && (c || q.rung_in);
    end else if (q.op inside {[OP_BIT_OUT:OP_BIT_LDC]}) begin
      kb = 1;
      kr = q.op > OP_BIT_CLR;
      e.err = n > (q.wide ? 31 : 15);
      if (!e.err) begin
        e.rung_out = w[n[4:0]] ^ (q.op == OP_BIT_LDC);
        e.dest_we = q.op == OP_BIT_OUT || (q.rung_in && q.op < OP_BIT_LDO);
        e.dest = w;
        e.dest[n[4:0]] = q.op == OP_BIT_SET || (q.op == OP_BIT_OUT && q.rung_in);
      end
    end else begin
      e.err = q.op != OP_ACC_TMR;
      kr = e.err;
    end
    return e;
  endfunction
  // one request, answer checked in the cycle after it stands
  task automatic exec(ladbc_req_s q);
    ladbc_rsp_s e;
    exp_q.push_back(model(q));
    @(posedge mclk) req <= q;
    @(posedge mclk) req.valid <= 1'b0;
    #1;
    e = exp_q.pop_front();
    chk("valid", 1, rsp_ff.valid);
    chk("err", e.err, rsp_ff.err);
    if (kr) chk("rung", e.rung_out, rsp_ff.rung_out);
    if (kb) chk("dest_we", e.dest_we, rsp_ff.dest_we);
    if (e.dest_we) chk("dest", e.dest, rsp_ff.dest);
    if (e.err) chk("prog_err", 1, prog_err_ff);
  endtask
  task automatic rnd();
    r = '0;
    r.valid = 1;
    {r.s1_hi, r.s1_lo} = $urandom;
    {r.s2_hi, r.s2_lo} = $urandom;
    {r.wide, r.ctr32, r.rung_in} = 3'($urandom);
  endtask
  initial begin
    int n;
    logic l;
    void'($urandom(11));
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    ce <= 1;
    for (int i = 0; i < 120; i++) begin
      rnd();
      r.op = ops[i % 6];
      r.ctr32 = r.ctr32 & r.wide;
      if (i % 3 == 0) {r.s2_hi, r.s2_lo} = {r.s1_hi, r.s1_lo};
      if (i % 3 == 1) r.s1_lo = 16'h8000;
      exec(r);
    end
    $display("compare test done");
    for (int i = 0; i < 160; i++) begin
      rnd();
      r.op = ops[6 + i % 5];
      r.s2_hi = 16'(i % 10 == 0);
      r.s2_lo = 16'($urandom % 40);
      exec(r);
    end
    $display("bit test done");
    rnd();
    r.op = OP_CMP_LT;
    r.wide = 0;
    r.ctr32 = 1;
    exec(r);
    r.op = 9'h000;
    exec(r);
    n = 0;
    l = err_led_ff;
    repeat (20) begin
      @(posedge mclk);
      #1;
      n += int'(err_led_ff !== l);
      l = err_led_ff;
    end
    chk("blink", 1, 32'(n >= 2));
    @(posedge mclk) err_clr <= 1;
    @(posedge mclk) err_clr <= 0;
    #1;
    chk("err_clear", 0, {prog_err_ff, err_led_ff});
    $display("error test done");
    r = '0;
    r.valid = 1;
    r.op = OP_ACC_TMR;
    r.rung_in = 1;
    r.s1_lo = 16'h0005;
    r.s2_lo = 16'h0002;
    exec(r);
    chk("coil", 1, tmr_coil_ff[5]);
    chk("early_done", 0, {tmr_done_ff[5], tmr_no_ff, ~tmr_nc_ff});
    repeat (3 * TICK) @(posedge mclk);
    #1;
    chk("done", 1, tmr_done_ff[5]);
    r.rung_in = 0;
    exec(r);
    chk("coil_off", 0, tmr_coil_ff[5]);
    chk("contacts", 2, {tmr_no_ff, tmr_nc_ff});
    r.rung_in = 1;
    r.s1_lo = 16'($urandom % 256);
    r.s2_lo = 16'h0000;
    exec(r);
    @(posedge mclk);
    #1;
    chk("zero_preset", 1, tmr_done_ff[r.s1_lo[7:0]]);
    // a request held while the enable is low must be neither answered nor executed
    r.s1_lo = r.s1_lo ^ 16'h0001;
    @(posedge mclk) begin
      ce <= 1'b0;
      req <= r;
    end
    repeat (3) @(posedge mclk);
    #1;
    chk("ce_hold", 0, {rsp_ff.valid, tmr_coil_ff[r.s1_lo[7:0]]});
    @(posedge mclk) ce <= 1'b1;
    @(posedge mclk) req.valid <= 1'b0;
    #1;
    chk("ce_run", 3, {rsp_ff.valid, tmr_coil_ff[r.s1_lo[7:0]]});
    $display("timer test done");
    conclude();
  end
endmodule
